//--- design/lbb_params.svh
`ifndef LBB_PARAMS_SVH
`define LBB_PARAMS_SVH
// Region descriptor field positions
`define LBB_DESC_RECOV_LSB      0
`define LBB_DESC_WAIT_LSB       2
`define LBB_DESC_READY_EN_BIT   6
`define LBB_DESC_BURST_BIT      7
`define LBB_DESC_BTERM_BIT      8
`define LBB_DESC_WIDTH_LSB      9
`define LBB_DESC_UPPER_LANE_BIT 11
`define LBB_DESC_ENDIAN_BIT     24
// Bus width codes
`define LBB_WIDTH_8  2'h0
`define LBB_WIDTH_16 2'h1
`define LBB_WIDTH_32 2'h2
// Bus mode strap values
`define LBB_MODE_NONMUX 1'h0
`define LBB_MODE_MUX    1'h1
// Space codes, boundary and recovery figures
`define LBB_ROM_SPACE   3'h4
`define LBB_QUAD_LAST   2'h3
`define LBB_MUX_MIN_REC 2'h1
`endif

//--- design/lbb_pkg.sv
`default_nettype none
package lbb_pkg;
  typedef enum logic [3:0] {
    LBB_IDLE  = 4'h1,
    LBB_LOAD  = 4'h2,
    LBB_DATA  = 4'h4,
    LBB_RECOV = 4'h8
  } lbb_state_type;
endpackage : lbb_pkg
`default_nettype wire

//--- design/lbb_burst_ctrl.sv
// Contract
// - Burst-4: last-beat when address bits 3:2 are 11, new strobe at 00.
// - Terminate ends burst after current beat without last-beat, then new strobe.
// - Terminate honoured only during a forwarded target transaction.
// - Terminate not sampled until the wait-state counter reaches zero.
// - Terminate beats ready; current beat completes, then new address cycle.
// - Burst-4 ends at four units or quad boundary per bus width.
// - Burst-4 starts on any long-word, stops at next 16-byte boundary.
// - Without terminate mode a burst is four beats: 4, 2 or 1 long-words.
// - Burst plus terminate mode: one address, unlimited burst until terminate.
// - Continuous: terminate acknowledges beat, new strobe carries next address.
// - Continuous: last-beat only when the transfer completes.
// - Single reads forward byte enables; burst reads enable all bytes.
// - Writes enable only host-enabled bytes, single and burst alike.
// - Unaligned burst start: one single cycle first, then burst from long-word.
// - Non-multiplexed: recovery clocks equal the recovery field, 0 to 3.
// - Multiplexed: at least one recovery clock; larger field values add more.
// - Ready held during last beat never adds recovery clocks.
// - Byte order per space from descriptor bit 24; only lanes swap.
// - 32-bit big endian: byte 0 on 31:24 down to byte 3 on 7:0.
// - 16-bit big endian: even byte upper lane of selected half, odd below.
// - 8-bit big endian upper lane: bytes 0..3 in order on 31:24.
// - 8-bit big endian lower lane: bytes 0..3 in order on 7:0.
// - Strap 0 selects non-multiplexed, 1 multiplexed bus mode.
`timescale 1ns/100ps
`default_nettype none
`include "lbb_params.svh"
module lbb_burst_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [31:0] reqAddr,
  input  wire logic [7:0]  reqCount,
  input  wire logic [2:0]  reqSpace,
  input  wire logic [3:0]  reqByteEn,
  output var  logic        reqReady,
  input  wire logic [31:0] wrData,
  output var  logic [7:0]  wordIndex,
  output var  logic [31:0] rdData,
  output var  logic        rdValid,
  output var  logic        xferDone,
  input  wire logic [31:0] space0_region_descriptor,
  input  wire logic [31:0] space1_region_descriptor,
  input  wire logic [31:0] space2_region_descriptor,
  input  wire logic [31:0] space3_region_descriptor,
  input  wire logic [31:0] rom_space_region_descriptor,
  input  wire logic        modeStrap,
  input  wire logic        local_ready_in_n,
  input  wire logic        burstTerminateInN,
  input  wire logic [31:0] local_addr_data_in,
  output var  logic [31:0] local_addr_data_out,
  output var  logic        local_addr_data_oe,
  output var  logic        address_strobe_out_n,
  output var  logic        last_beat_out_n,
  output var  logic [31:0] local_addr,
  output var  logic [3:0]  byteEnableOutN,
  output var  logic        writeNotRead
);

  lbb_pkg::lbb_state_type state_q;
  logic [1:0]  readySync_q;
  logic [1:0]  btermSync_q;
  logic [1:0]  modeSync_q;
  logic [31:0] ladSync1_q;
  logic [31:0] ladSync2_q;
  logic [2:0]  space_q;
  logic        write_q;
  logic [3:0]  byteEn_q;
  logic [31:0] beatAddr_q;
  logic [1:0]  beatInWord_q;
  logic [1:0]  curBeat_q;
  logic [7:0]  wordsLeft_q;
  logic        firstSingle_q;
  logic        needAds_q;
  logic        curLast_q;
  logic        curFinal_q;
  logic        curWordEnd_q;
  logic [3:0]  waitCnt_q;
  logic [1:0]  recCnt_q;
  logic [31:0] wordBuf_q;
  logic [31:0] dataHold_q;
  logic [31:0] rdBuf_q;
  logic [31:0] desc;
  logic [1:0]  width;
  logic [1:0]  bpwM1;
  logic [1:0]  boundary;
  logic [1:0]  recovCount;
  logic [31:0] wordNow;
  logic [31:0] steerData;
  logic [3:0]  steerBeN;
  logic [31:0] rdMerge;
  logic [1:0]  lane;
  logic        descBurst;
  logic        descBterm;
  logic        descBig;
  logic        descUpper;
  logic        modeMux;
  logic        singleNow;
  logic        lastData;
  logic        lastThis;
  logic        btermHit;
  logic        ack;
  logic        take;

  // Byte lane for a byte of the long-word, per width, order and lane choice
  function automatic logic [1:0] laneOf(input logic [1:0] b, input logic [1:0] w,
                                        input logic big, input logic up);
    if (w == `LBB_WIDTH_32)
      laneOf = big ? ~b : b;
    else if (w == `LBB_WIDTH_16)
      laneOf = big ? {up, ~b[0]} : {up, b[0]};
    else
      laneOf = {up, up};
  endfunction : laneOf

  // Whether a byte of the long-word travels in the given beat
  function automatic logic inBeat(input logic [1:0] b, input logic [1:0] beat,
                                  input logic [1:0] w);
    if (w == `LBB_WIDTH_32)
      inBeat = 1'b1;
    else if (w == `LBB_WIDTH_16)
      inBeat = (b[1] == beat[0]);
    else
      inBeat = (b == beat);
  endfunction : inBeat

  // Pin inputs pass two flops; strap sampled continuously as a level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      readySync_q <= 2'h0;
      btermSync_q <= 2'h0;
      modeSync_q  <= 2'h0;
      ladSync1_q  <= 32'h0;
      ladSync2_q  <= 32'h0;
    end
    else
    begin
      readySync_q <= {readySync_q[0], ~local_ready_in_n};
      btermSync_q <= {btermSync_q[0], ~burstTerminateInN};
      modeSync_q  <= {modeSync_q[0], modeStrap};
      ladSync1_q  <= local_addr_data_in;
      ladSync2_q  <= ladSync1_q;
    end
  end

  // Descriptor of the active space and its fields
  always_comb
  begin
    case (space_q)
      3'h0:    desc = space0_region_descriptor;
      3'h1:    desc = space1_region_descriptor;
      3'h2:    desc = space2_region_descriptor;
      3'h3:    desc = space3_region_descriptor;
      default: desc = rom_space_region_descriptor;
    endcase
  end

  assign width     = desc[`LBB_DESC_WIDTH_LSB +: 2];
  assign descBurst = desc[`LBB_DESC_BURST_BIT];
  assign descBterm = desc[`LBB_DESC_BTERM_BIT];
  assign descBig   = desc[`LBB_DESC_ENDIAN_BIT];
  assign descUpper = desc[`LBB_DESC_UPPER_LANE_BIT];
  assign modeMux   = (modeSync_q[1] == `LBB_MODE_MUX);
  assign bpwM1     = (width == `LBB_WIDTH_8) ? 2'h3 : (width == `LBB_WIDTH_16) ? 2'h1 : 2'h0;

  // Quad boundary bits move down with the bus width
  assign boundary  = (width == `LBB_WIDTH_8)  ? beatAddr_q[1:0] :
                     (width == `LBB_WIDTH_16) ? beatAddr_q[2:1] : beatAddr_q[3:2];

  // Multiplexed bus never drops below one recovery clock; ready plays no part
  assign recovCount = (modeMux && desc[`LBB_DESC_RECOV_LSB +: 2] == 2'h0) ? `LBB_MUX_MIN_REC
                    : desc[`LBB_DESC_RECOV_LSB +: 2];

  // Last-beat decision for the beat about to be loaded
  assign singleNow = !descBurst || firstSingle_q;
  assign lastData  = (wordsLeft_q == 8'h1) && (beatInWord_q == bpwM1);
  assign lastThis  = singleNow || lastData ||
                     (!descBterm && boundary == `LBB_QUAD_LAST);

  // Terminate counts only in the data phase after the wait counter expires
  assign btermHit = (state_q == lbb_pkg::LBB_DATA) && descBterm && btermSync_q[1] &&
                    address_strobe_out_n && (waitCnt_q == 4'h0);
  assign ack      = (state_q == lbb_pkg::LBB_DATA) && address_strobe_out_n &&
                    (waitCnt_q == 4'h0) &&
                    (btermHit || !desc[`LBB_DESC_READY_EN_BIT] || readySync_q[1]);
  assign take     = reqValid && reqReady && (reqCount != 8'h0);
  assign wordNow  = (beatInWord_q == 2'h0) ? wrData : wordBuf_q;

  // Lane steering for outgoing data, byte enables and incoming read bytes
  always_comb
  begin
    steerData = 32'h0;
    steerBeN  = 4'hf;
    rdMerge   = rdBuf_q;
    lane      = 2'h0;
    for (int b = 0; b < 4; b++)
    begin
      if (inBeat(2'(b), beatInWord_q, width))
      begin
        lane = laneOf(2'(b), width, descBig, descUpper);
        steerData[lane*8 +: 8] = wordNow[b*8 +: 8];
        steerBeN[lane] = (write_q || singleNow) ? ~byteEn_q[b] : 1'b0;
      end
      if (inBeat(2'(b), curBeat_q, width))
      begin
        lane = laneOf(2'(b), width, descBig, descUpper);
        rdMerge[b*8 +: 8] = ladSync2_q[lane*8 +: 8];
      end
    end
  end

  // Cycle sequencing: load a beat, hold it until acknowledged, recover
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q       <= lbb_pkg::LBB_IDLE;
      reqReady      <= 1'b1;
      space_q       <= 3'h0;
      write_q       <= 1'b0;
      byteEn_q      <= 4'h0;
      beatAddr_q    <= 32'h0;
      beatInWord_q  <= 2'h0;
      curBeat_q     <= 2'h0;
      wordsLeft_q   <= 8'h0;
      wordIndex     <= 8'h0;
      firstSingle_q <= 1'b0;
      needAds_q     <= 1'b0;
      curLast_q     <= 1'b0;
      curFinal_q    <= 1'b0;
      curWordEnd_q  <= 1'b0;
      waitCnt_q     <= 4'h0;
      recCnt_q      <= 2'h0;
      wordBuf_q     <= 32'h0;
      xferDone      <= 1'b0;
    end
    else
    begin
      xferDone <= 1'b0;
      case (state_q)
        lbb_pkg::LBB_IDLE:
        begin
          if (take)
          begin
            reqReady      <= 1'b0;
            space_q       <= reqSpace;
            write_q       <= reqWrite;
            byteEn_q      <= reqByteEn;
            wordsLeft_q   <= reqCount;
            wordIndex     <= 8'h0;
            beatAddr_q    <= {reqAddr[31:2], 2'h0};
            beatInWord_q  <= 2'h0;
            firstSingle_q <= (reqAddr[1:0] != 2'h0);
            needAds_q     <= 1'b1;
            state_q       <= lbb_pkg::LBB_LOAD;
          end
        end
        lbb_pkg::LBB_LOAD:
        begin
          curBeat_q    <= beatInWord_q;
          curLast_q    <= lastThis;
          curFinal_q   <= lastData;
          curWordEnd_q <= (beatInWord_q == bpwM1);
          waitCnt_q    <= desc[`LBB_DESC_WAIT_LSB +: 4];
          beatAddr_q   <= beatAddr_q + ((width == `LBB_WIDTH_8)  ? 32'h1 :
                                        (width == `LBB_WIDTH_16) ? 32'h2 : 32'h4);
          if (beatInWord_q == 2'h0)
          begin
            wordBuf_q <= wrData;
            wordIndex <= wordIndex + 8'h1;
          end
          beatInWord_q <= (beatInWord_q == bpwM1) ? 2'h0 : beatInWord_q + 2'h1;
          state_q      <= lbb_pkg::LBB_DATA;
        end
        lbb_pkg::LBB_DATA:
        begin
          if (address_strobe_out_n && waitCnt_q != 4'h0)
            waitCnt_q <= waitCnt_q - 4'h1;
          if (ack)
          begin
            if (curWordEnd_q)
            begin
              wordsLeft_q   <= wordsLeft_q - 8'h1;
              firstSingle_q <= 1'b0;
            end
            // A terminated or closed burst needs a new address cycle
            needAds_q <= curLast_q || btermHit;
            recCnt_q  <= recovCount;
            xferDone  <= curFinal_q;
            if (curFinal_q || curLast_q || btermHit)
              state_q <= (recovCount != 2'h0) ? lbb_pkg::LBB_RECOV :
                         curFinal_q ? lbb_pkg::LBB_IDLE : lbb_pkg::LBB_LOAD;
            else
              state_q <= lbb_pkg::LBB_LOAD;
            reqReady <= curFinal_q && (recovCount == 2'h0);
          end
        end
        lbb_pkg::LBB_RECOV:
        begin
          recCnt_q <= recCnt_q - 2'h1;
          if (recCnt_q == 2'h1)
          begin
            state_q  <= curFinal_q ? lbb_pkg::LBB_IDLE : lbb_pkg::LBB_LOAD;
            reqReady <= curFinal_q;
          end
        end
        default:
        begin
          state_q  <= lbb_pkg::LBB_IDLE;
          reqReady <= 1'b1;
        end
      endcase
    end
  end

  // Local bus pins; in multiplexed mode the address rides the data lines first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      address_strobe_out_n <= 1'b1;
      last_beat_out_n      <= 1'b1;
      local_addr           <= 32'h0;
      local_addr_data_out  <= 32'h0;
      local_addr_data_oe   <= 1'b0;
      byteEnableOutN       <= 4'hf;
      writeNotRead         <= 1'b0;
      dataHold_q           <= 32'h0;
    end
    else if (state_q == lbb_pkg::LBB_LOAD)
    begin
      address_strobe_out_n <= ~needAds_q;
      last_beat_out_n      <= ~lastThis;
      local_addr           <= beatAddr_q;
      local_addr_data_out  <= (modeMux && needAds_q) ? beatAddr_q : steerData;
      local_addr_data_oe   <= write_q || (modeMux && needAds_q);
      byteEnableOutN       <= steerBeN;
      writeNotRead         <= write_q;
      dataHold_q           <= steerData;
    end
    else if (state_q == lbb_pkg::LBB_DATA)
    begin
      address_strobe_out_n <= 1'b1;
      if (!address_strobe_out_n)
      begin
        local_addr_data_out <= dataHold_q;
        local_addr_data_oe  <= write_q;
      end
      if (ack)
      begin
        last_beat_out_n    <= 1'b1;
        local_addr_data_oe <= 1'b0;
        byteEnableOutN     <= 4'hf;
      end
    end
  end

  // Read bytes gather per long-word; one pulse per finished word
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdBuf_q <= 32'h0;
      rdData  <= 32'h0;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      if (ack && !write_q)
      begin
        rdBuf_q <= rdMerge;
        if (curWordEnd_q)
        begin
          rdData  <= rdMerge;
          rdValid <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_single_ads;
    (state_q == lbb_pkg::LBB_LOAD && !descBurst) |=> (!address_strobe_out_n && !last_beat_out_n);
  endproperty
  a_single_ads: assert property (p_single_ads) else $error("single cycle lacks strobe");

  property p_quad_last;
    (state_q == lbb_pkg::LBB_LOAD && !descBterm && boundary == 2'h3) |=> !last_beat_out_n;
  endproperty
  a_quad_last: assert property (p_quad_last) else $error("no last beat at quad boundary");

  property p_cont_no_last;
    (state_q == lbb_pkg::LBB_LOAD && descBurst && descBterm && !lastData && !firstSingle_q)
      |=> last_beat_out_n;
  endproperty
  a_cont_no_last: assert property (p_cont_no_last) else $error("early last beat");

  property p_wait_blocks;
    (state_q == lbb_pkg::LBB_DATA && waitCnt_q != 4'h0) |-> (!ack && !btermHit);
  endproperty
  a_wait_blocks: assert property (p_wait_blocks) else $error("acked during wait states");

  property p_bterm_readdr;
    (btermHit && !curFinal_q && recovCount == 2'h0)
      |=> (state_q == lbb_pkg::LBB_LOAD) ##1 !address_strobe_out_n;
  endproperty
  a_bterm_readdr: assert property (p_bterm_readdr) else $error("no new strobe after terminate");

  property p_rec_nonmux;
    (ack && curLast_q && !curFinal_q && !modeMux && desc[1:0] == 2'h2)
      |=> (state_q == lbb_pkg::LBB_RECOV) [*2] ##1 (state_q == lbb_pkg::LBB_LOAD);
  endproperty
  a_rec_nonmux: assert property (p_rec_nonmux) else $error("wrong recovery length");

  property p_rec_mux;
    (ack && curLast_q && !curFinal_q && modeMux && desc[1:0] == 2'h0)
      |=> (state_q == lbb_pkg::LBB_RECOV) ##1 (state_q == lbb_pkg::LBB_LOAD);
  endproperty
  a_rec_mux: assert property (p_rec_mux) else $error("multiplexed recovery missing");

  property p_big32;
    (state_q == lbb_pkg::LBB_LOAD && write_q && width == `LBB_WIDTH_32 && descBig &&
     !(modeMux && needAds_q))
      |=> (local_addr_data_out == {$past(wordNow[7:0]), $past(wordNow[15:8]),
                                   $past(wordNow[23:16]), $past(wordNow[31:24])});
  endproperty
  a_big32: assert property (p_big32) else $error("big endian lanes wrong");

  property p_burst_read_be;
    (state_q == lbb_pkg::LBB_LOAD && !write_q && !singleNow && width == `LBB_WIDTH_32)
      |=> (byteEnableOutN == 4'h0);
  endproperty
  a_burst_read_be: assert property (p_burst_read_be) else $error("burst read masked");

  property p_unaligned;
    (take && reqAddr[1:0] != 2'h0) |=> ##1 (!last_beat_out_n && !address_strobe_out_n);
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned start not single");

endmodule : lbb_burst_ctrl
`default_nettype wire

//--- verif/lbb_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module lbb_slave_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        strobeN,
  input  wire logic [31:0] localAddr,
  input  wire logic [31:0] dataOut,
  input  wire logic        lastN,
  input  wire logic [3:0]  beN,
  input  wire logic [7:0]  termAt,
  input  wire logic        bothAck,
  output var  logic        readyN,
  output var  logic        termN,
  output var  logic [31:0] dataIn
);
  logic [1:0]  phase;
  logic [7:0]  beatIdx;
  logic        logged;
  logic        prevActive;
  logic [31:0] addrLog[$];
  logic [31:0] dataLog[$];
  logic [3:0]  beLog[$];
  logic [31:0] lastLog[$];

  function automatic logic [31:0] readWord(input logic [31:0] a);
    return {8'hc3, a[7:0], 8'h3c, a[15:8]};
  endfunction : readWord

  // Acks one cycle in four so a pulse lands after any wait states; idle lines float high
  always @(posedge clk)
  begin
    if (reset)
    begin
      phase <= 2'h0; beatIdx <= 8'h0; logged <= 1'b0; prevActive <= 1'b0;
      readyN <= 1'b1; termN <= 1'b1; dataIn <= 32'h0;
    end
    else
    begin
      prevActive <= (beN != 4'hf);
      if (prevActive && beN == 4'hf)
      begin
        beatIdx <= beatIdx + 8'h1;
        logged  <= 1'b0;
      end
      if (beN != 4'hf && strobeN && phase == 2'h0)
      begin
        termN  <= !(beatIdx == termAt);
        readyN <= (beatIdx == termAt) && !bothAck;
        dataIn <= readWord(localAddr);
        if (!logged)
        begin
          addrLog.push_back(localAddr); dataLog.push_back(dataOut);
          beLog.push_back(beN); lastLog.push_back({31'h0, lastN});
          logged <= 1'b1;
        end
      end
      else
      begin
        readyN <= 1'b1; termN <= 1'b1;
        dataIn <= ~dataIn; // Stale data never looks valid
      end
      phase <= (beN != 4'hf && strobeN) ? phase + 2'h1 : 2'h0;
    end
  end
endmodule : lbb_slave_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lbb_params.svh"
module tb;
  logic clk = 1'b0, reset = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, modeStrap = 1'b0;
  logic [31:0] reqAddr = 32'h0, wrData, rdData, ladOut, ladIn, localAddr;
  logic [7:0]  reqCount = 8'h0, wordIndex, termAt = 8'hff;
  logic [2:0]  reqSpace = 3'h0;
  logic [3:0]  reqByteEn = 4'hf, beN;
  logic [31:0] desc[0:4], wrWords[0:7];
  logic        reqReady, rdValid, xferDone, ladOe, strobeN, lastN, wnr, readyN, termN;
  logic        bothAck = 1'b0, prevLast = 1'b1;
  int          n_fail = 0, n_compared = 0, cyc = 0, gap[0:1][0:3];
  int          strobeCyc[$], lastEndCyc[$];
  logic [31:0] rdLog[$];

  always #50 clk = ~clk;
  assign wrData = wrWords[wordIndex[2:0]];

  lbb_burst_ctrl lbb_burst_ctrl_i (.clk(clk), .reset(reset), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqCount(reqCount), .reqSpace(reqSpace),
    .reqByteEn(reqByteEn), .reqReady(reqReady), .wrData(wrData), .wordIndex(wordIndex),
    .rdData(rdData), .rdValid(rdValid), .xferDone(xferDone),
    .space0_region_descriptor(desc[0]), .space1_region_descriptor(desc[1]),
    .space2_region_descriptor(desc[2]), .space3_region_descriptor(desc[3]),
    .rom_space_region_descriptor(desc[4]), .modeStrap(modeStrap),
    .local_ready_in_n(readyN), .burstTerminateInN(termN), .local_addr_data_in(ladIn),
    .local_addr_data_out(ladOut), .local_addr_data_oe(ladOe),
    .address_strobe_out_n(strobeN), .last_beat_out_n(lastN), .local_addr(localAddr),
    .byteEnableOutN(beN), .writeNotRead(wnr));

  lbb_slave_model lbb_slave_model_i (.clk(clk), .reset(reset), .strobeN(strobeN),
    .localAddr(localAddr), .dataOut(ladOut), .lastN(lastN), .beN(beN), .termAt(termAt),
    .bothAck(bothAck), .readyN(readyN), .termN(termN), .dataIn(ladIn));

  // Cycle stamps of strobes and last-beat ends, and every read word
  always @(posedge clk)
  begin
    cyc++;
    if (strobeN === 1'b0) strobeCyc.push_back(cyc);
    if (prevLast === 1'b0 && lastN === 1'b1) lastEndCyc.push_back(cyc);
    prevLast = lastN;
    if (rdValid === 1'b1) rdLog.push_back(rdData);
  end

  function automatic logic [31:0] mk(input logic [1:0] rc, input logic [3:0] ws,
    input logic bu, input logic bt, input logic [1:0] wd, input logic up, input logic bg);
    logic [31:0] d;
    d = 32'h0; d[1:0] = rc; d[5:2] = ws; d[`LBB_DESC_READY_EN_BIT] = 1'b1;
    d[`LBB_DESC_BURST_BIT] = bu; d[`LBB_DESC_BTERM_BIT] = bt; d[10:9] = wd;
    d[`LBB_DESC_UPPER_LANE_BIT] = up; d[`LBB_DESC_ENDIAN_BIT] = bg;
    return d;
  endfunction : mk

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Bounded wait on a flag; running out closes the run
  task automatic waitFor(ref logic sig, input string what);
    int i;
    for (i = 0; i < 3000 && sig !== 1'b1; i++) tick;
    if (sig !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: timeout on %s", $time, what);
      wrap_up;
    end
  endtask : waitFor

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] n,
    input logic [2:0] sp, input logic [3:0] be);
    strobeCyc.delete(); lastEndCyc.delete(); rdLog.delete();
    lbb_slave_model_i.addrLog.delete(); lbb_slave_model_i.dataLog.delete();
    lbb_slave_model_i.beLog.delete(); lbb_slave_model_i.lastLog.delete();
    waitFor(reqReady, "ready");
    reqWrite = wr; reqAddr = a; reqCount = n; reqSpace = sp; reqByteEn = be;
    reqValid = 1'b1;
    tick;
    reqValid = 1'b0;
    waitFor(xferDone, "done");
    tick;
    waitFor(reqReady, "recovery");
    repeat (4) tick;
  endtask : xfer

  task automatic sc_single;
    int b, k;
    for (b = 0; b < 2; b++)
    begin
      desc[0] = mk(2'h0, 4'h0, 1'b0, b[0], `LBB_WIDTH_32, 1'b0, 1'b0);
      xfer(1'b1, 32'h100, 8'h3, 3'h0, 4'hf);
      check(32'(strobeCyc.size()), 32'h3, "strobes");
      for (k = 0; k < 3; k++)
      begin
        check(lbb_slave_model_i.lastLog[k], 32'h0, "last");
        check(lbb_slave_model_i.dataLog[k], wrWords[k], "data");
      end
    end
  endtask : sc_single

  task automatic sc_burst4;
    int w, k;
    for (w = 0; w < 3; w++)
    begin
      desc[0] = mk(2'h0, 4'h0, 1'b1, 1'b0, w[1:0], 1'b0, 1'b0);
      xfer(1'b1, 32'h100, 8'(1 << w), 3'h0, 4'hf);
      check(32'(strobeCyc.size()), 32'h1, "strobes");
      for (k = 0; k < 4; k++)
      begin
        check(lbb_slave_model_i.addrLog[k], 32'h100 + (k << w), "addr");
        check(lbb_slave_model_i.lastLog[k], 32'(k != 3), "last");
      end
    end
    desc[0] = mk(2'h0, 4'h0, 1'b1, 1'b0, `LBB_WIDTH_32, 1'b0, 1'b0);
    xfer(1'b1, 32'h108, 8'h6, 3'h0, 4'hf);
    check(32'(strobeCyc.size()), 32'h2, "strobes");
    for (k = 0; k < 6; k++)
    begin
      check(lbb_slave_model_i.addrLog[k], 32'h108 + 4 * k, "addr");
      check(lbb_slave_model_i.lastLog[k], 32'(k != 1 && k != 5), "last");
    end
  endtask : sc_burst4

  task automatic sc_term;
    int k;
    desc[0] = mk(2'h0, 4'h2, 1'b1, 1'b1, `LBB_WIDTH_32, 1'b0, 1'b0);
    termAt = lbb_slave_model_i.beatIdx + 8'h1;
    bothAck = 1'b1;
    xfer(1'b1, 32'h200, 8'h5, 3'h0, 4'hf);
    termAt = 8'hff;
    bothAck = 1'b0;
    check(32'(strobeCyc.size()), 32'h2, "strobes");
    check(lbb_slave_model_i.addrLog[2], 32'h208, "next addr");
    for (k = 0; k < 5; k++)
      check(lbb_slave_model_i.lastLog[k], 32'(k != 4), "last");
  endtask : sc_term

  task automatic sc_lanes;
    logic [1:0]  wd[0:5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
    logic        up[0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [31:0] m, e;
    logic [7:0]  b0, b1;
    int i, k;
    wrWords[0] = 32'h44332211;
    for (i = 0; i < 6; i++)
    begin
      desc[i % 5] = mk(2'h0, 4'h0, 1'b0, 1'b0, wd[i], up[i], i != 5);
      xfer(1'b1, 32'h300, 8'h1, 3'(i % 5), 4'hf);
      for (k = 0; k < (4 >> wd[i]); k++)
      begin
        // 16-bit beats carry two bytes each, 8-bit beats one
        b0 = 8'(8'h11 * (k * (1 + (wd[i] == 2'h1)) + 1));
        b1 = b0 + 8'h11;
        m  = 32'hffffffff;
        e  = (i != 5) ? 32'h11223344 : wrWords[0];
        if (wd[i] == 2'h1)
        begin
          m = up[i] ? 32'hffff0000 : 32'h0000ffff;
          e = {b0, b1, b0, b1};
        end
        else if (wd[i] == 2'h0)
        begin
          m = up[i] ? 32'hff000000 : 32'h000000ff;
          e = {4{b0}};
        end
        check(lbb_slave_model_i.dataLog[k] & m, e & m, "lanes");
      end
    end
    wrWords[0] = 32'hcafe0001;
  endtask : sc_lanes

  task automatic sc_byteen;
    int k;
    desc[0] = mk(2'h0, 4'h0, 1'b0, 1'b0, `LBB_WIDTH_32, 1'b0, 1'b0);
    xfer(1'b1, 32'h300, 8'h1, 3'h0, 4'h5);
    check(lbb_slave_model_i.beLog[0], 4'ha, "single write enables");
    check(wnr, 1'b1, "write direction");
    xfer(1'b0, 32'h300, 8'h1, 3'h0, 4'h6);
    check(lbb_slave_model_i.beLog[0], 4'h9, "single read enables");
    check(wnr, 1'b0, "read direction");
    desc[0] = mk(2'h0, 4'h0, 1'b1, 1'b0, `LBB_WIDTH_32, 1'b0, 1'b0);
    xfer(1'b0, 32'h300, 8'h4, 3'h0, 4'h6);
    for (k = 0; k < 4; k++)
    begin
      check(lbb_slave_model_i.beLog[k], 4'h0, "burst read enables");
      check(rdLog[k], lbb_slave_model_i.readWord(32'h300 + 4 * k), "read data");
    end
    xfer(1'b1, 32'h300, 8'h4, 3'h0, 4'h6);
    for (k = 0; k < 4; k++)
      check(lbb_slave_model_i.beLog[k], 4'h9, "burst write enables");
  endtask : sc_byteen

  task automatic sc_unaligned;
    desc[0] = mk(2'h0, 4'h0, 1'b1, 1'b0, `LBB_WIDTH_32, 1'b0, 1'b0);
    xfer(1'b1, 32'h102, 8'h3, 3'h0, 4'hf);
    check(32'(strobeCyc.size()), 32'h2, "strobes");
    check(lbb_slave_model_i.lastLog[0], 32'h0, "single first");
    check(lbb_slave_model_i.addrLog[1], 32'h104, "burst start");
  endtask : sc_unaligned

  task automatic sc_recov;
    int md, f;
    for (md = 0; md < 2; md++)
      for (f = 0; f < 4; f++)
      begin
        modeStrap = md[0];
        repeat (4) tick;
        desc[0] = mk(f[1:0], 4'h0, 1'b0, 1'b0, `LBB_WIDTH_32, 1'b0, 1'b0);
        xfer(1'b1, 32'h400, 8'h2, 3'h0, 4'hf);
        gap[md][f] = strobeCyc[1] - lastEndCyc[0];
      end
    // Zero recovery leaves only the one load cycle between beats
    check(32'(gap[0][0]), 32'h1, "no recovery");
    for (f = 0; f < 4; f++)
    begin
      check(32'(gap[0][f] - gap[0][0]), 32'(f), "recovery nonmux");
      check(32'(gap[1][f]), 32'(gap[0][(f > 1) ? f : 1]), "recovery mux");
    end
    modeStrap = 1'b0;
  endtask : sc_recov

  // Reset, idle checks, then each scenario in turn
  initial
  begin
    for (int i = 0; i < 5; i++) desc[i] = mk(2'h0, 4'h0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) wrWords[i] = 32'ha5000000 + 32'h01010101 * i;
    repeat (20) tick;
    reset = 1'b0;
    tick;
    check({strobeN, lastN, ladOe, beN, reqReady}, 32'hdf, "idle outputs");
    sc_single;
    sc_burst4;
    sc_term;
    sc_lanes;
    sc_byteen;
    sc_unaligned;
    sc_recov;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
